/* verilog/uart_ctrl_parity_baud.sv */
// Serial port with parity, prescaler and baud divisor
//
// Overview of operation
// - Low control register at F3h
// - Low control register resets to zero
// - Bit 7 parity autogen, bit 6 odd select
// - Bit 5 rx odd check, bit 4 error
// - Bit 1 tx irq enable, bit 0 pending
// - Mode 0 rx pending at eighth midpoint
// - Mode 1 rx pending at stop midpoint
// - Modes 2,3 rx pending at ninth midpoint
// - Mode 0 tx pending after eighth bit
// - Modes 1-3 tx pending at stop start
// - Baud divisor at F5h, reset zero
// - Mode 2 rate prescaled clock/16, divisor ignored
// - Modes 0,1,3 rate prescaled clock/(16*(div+1))
// - High control mode field selects mode
// - Data write loads tx, read rx
// - Data write starts transmission
`timescale 1ns/100ps
module uart_ctrl_parity_baud
   import uart_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_ff,
   input wire logic serial_in_pin,
   output logic serial_out_pin_ff,
   output logic serial_data_out_ff,
   output logic serial_data_oe_ff,
   output logic tx_irq_ff,
   output logic rx_irq_ff
);
   logic [7:0] uart_ctrl_low_ff;
   logic [7:0] uart_ctrl_high_ff;
   logic [7:0] baud_divisor_ff;
   logic [7:0] rx_buf_ff;
   logic [7:0] tx_buf_ff;
   logic in_meta_ff;
   logic in_sync_ff;
   logic tick;
   logic [1:0] mode;
   logic par_en;
   logic wr_low, wr_high, wr_data, wr_baud;
   logic tx_done_evt, rx_done_evt, rx_err_evt, rx_ok_err, rx_ninth;
   typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_START = 2'h1,
      TX_DATA = 2'h3, TX_STOP = 2'h2} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1,
      RX_DATA = 2'h3, RX_STOP = 2'h2} rx_state_t;
   tx_state_t tx_st_ff;
   rx_state_t rx_st_ff;
   logic [3:0] tx_tk_ff, rx_tk_ff, tx_bit_ff, rx_bit_ff;
   logic [8:0] tx_sh_ff, rx_sh_ff;
   assign mode = uart_ctrl_high_ff[HI_MODE_HI:HI_MODE_LO];
   assign par_en = uart_ctrl_low_ff[LO_TX_PAR_EN];
   assign wr_low = reg_wr && reg_addr == ADDR_CTRL_LOW;
   assign wr_high = reg_wr && reg_addr == ADDR_CTRL_HIGH;
   assign wr_data = reg_wr && reg_addr == ADDR_DATA;
   assign wr_baud = reg_wr && reg_addr == ADDR_BAUD;
   // Pin input passes two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta_ff <= 1'b1;
         in_sync_ff <= 1'b1;
      end else begin
         in_meta_ff <= serial_in_pin;
         in_sync_ff <= in_meta_ff;
      end
   end
   // Prescaler and divisor tick at sixteen per bit
   rate_gen u_rate (
      .clk(clk),
      .rst_n(rst_n),
      .clk_sel(uart_ctrl_low_ff[LO_CLK_HI:LO_CLK_LO]),
      .mode(mode),
      .divisor(baud_divisor_ff),
      .tick(tick)
   );
   // Low control register; hardware sets beat software clears
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uart_ctrl_low_ff <= CTRL_LOW_RESET;
      end else begin
         if (wr_low) begin
            uart_ctrl_low_ff[7:1] <= reg_wdata[7:1];
            if (!reg_wdata[LO_TX_PEND])
               uart_ctrl_low_ff[LO_TX_PEND] <= 1'b0;
         end
         if (tx_done_evt)
            uart_ctrl_low_ff[LO_TX_PEND] <= 1'b1;
         if (rx_err_evt)
            uart_ctrl_low_ff[LO_PAR_ERR] <= rx_ok_err;
      end
   end
   // High control register, rx pending and ninth bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uart_ctrl_high_ff <= CTRL_HIGH_RESET;
      end else begin
         if (wr_high) begin
            uart_ctrl_high_ff[7:1] <= reg_wdata[7:1];
            if (!reg_wdata[HI_RX_PEND])
               uart_ctrl_high_ff[HI_RX_PEND] <= 1'b0;
         end
         if (rx_done_evt) begin
            uart_ctrl_high_ff[HI_RX_PEND] <= 1'b1;
            if (mode[1])
               uart_ctrl_high_ff[HI_RX_NINTH] <= rx_ninth;
         end
      end
   end
   // Baud divisor and transmit buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_divisor_ff <= BAUD_RESET;
         tx_buf_ff <= DATA_RESET;
      end else begin
         if (wr_baud)
            baud_divisor_ff <= reg_wdata;
         if (wr_data)
            tx_buf_ff <= reg_wdata;
      end
   end
   // Registered read data; separate receive buffer at data address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL_HIGH: reg_rdata_ff <= uart_ctrl_high_ff;
            ADDR_CTRL_LOW: reg_rdata_ff <= uart_ctrl_low_ff;
            ADDR_DATA: reg_rdata_ff <= rx_buf_ff;
            ADDR_BAUD: reg_rdata_ff <= baud_divisor_ff;
            default: reg_rdata_ff <= 8'h00;
         endcase
      end
   end
   // Interrupt request lines follow pending and enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_irq_ff <= 1'b0;
         rx_irq_ff <= 1'b0;
      end else begin
         tx_irq_ff <= uart_ctrl_low_ff[LO_TX_IE] &
            uart_ctrl_low_ff[LO_TX_PEND];
         rx_irq_ff <= uart_ctrl_high_ff[HI_RX_IE] &
            uart_ctrl_high_ff[HI_RX_PEND];
      end
   end
   // Transmitter: start, data (8 or 9), stop; mode 0 shifts 8 bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_st_ff <= TX_IDLE;
         tx_tk_ff <= 4'h0;
         tx_bit_ff <= 4'h0;
         tx_sh_ff <= 9'h000;
         serial_out_pin_ff <= 1'b1;
         serial_data_out_ff <= 1'b1;
         serial_data_oe_ff <= 1'b0;
         tx_done_evt <= 1'b0;
      end else begin
         tx_done_evt <= 1'b0;
         if (wr_data) begin
            tx_tk_ff <= 4'h0;
            tx_bit_ff <= 4'h0;
            // Ninth bit is parity when autogen is on, else from control
            tx_sh_ff <= {par_en ? (^reg_wdata ^
               uart_ctrl_low_ff[LO_TX_PAR_ODD]) :
               uart_ctrl_high_ff[HI_TX_NINTH], reg_wdata};
            if (mode == MODE_SHIFT) begin
               tx_st_ff <= TX_DATA;
               serial_data_oe_ff <= 1'b1;
               serial_data_out_ff <= reg_wdata[0];
            end else begin
               tx_st_ff <= TX_START;
               serial_out_pin_ff <= 1'b0;
            end
         end else if (tick && tx_st_ff != TX_IDLE) begin
            tx_tk_ff <= tx_tk_ff + 4'h1;
            if (mode == MODE_SHIFT) begin
               // Shift clock low in first half of each bit
               serial_out_pin_ff <= tx_tk_ff >= TICKS_MID;
            end
            if (tx_tk_ff == TICKS_LAST) begin
               unique case (tx_st_ff)
                  TX_START: begin
                     tx_st_ff <= TX_DATA;
                     serial_out_pin_ff <= tx_sh_ff[0];
                  end
                  TX_DATA: begin
                     tx_bit_ff <= tx_bit_ff + 4'h1;
                     tx_sh_ff <= {1'b0, tx_sh_ff[8:1]};
                     if (mode == MODE_SHIFT) begin
                        serial_data_out_ff <= tx_sh_ff[1];
                        if (tx_bit_ff == MODE0_BITS_LAST) begin
                           tx_st_ff <= TX_IDLE;
                           serial_data_oe_ff <= 1'b0;
                           tx_done_evt <= 1'b1;
                        end
                     end else if (tx_bit_ff == (mode[1] ? 4'h8 : 4'h7)) begin
                        tx_st_ff <= TX_STOP;
                        serial_out_pin_ff <= 1'b1;
                        tx_done_evt <= 1'b1;
                     end else begin
                        serial_out_pin_ff <= tx_sh_ff[1];
                     end
                  end
                  TX_STOP: tx_st_ff <= TX_IDLE;
                  default: tx_st_ff <= TX_IDLE;
               endcase
            end
         end
      end
   end
   // Receiver: start detect, sample at midpoints, flag on ninth midpoint in modes 2,3, else on last midpoint
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_ff <= RX_IDLE;
         rx_tk_ff <= 4'h0;
         rx_bit_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
         rx_buf_ff <= DATA_RESET;
         rx_done_evt <= 1'b0;
         rx_err_evt <= 1'b0;
         rx_ok_err <= 1'b0;
         rx_ninth <= 1'b0;
      end else begin
         rx_done_evt <= 1'b0;
         rx_err_evt <= 1'b0;
         if (!uart_ctrl_high_ff[HI_RX_EN]) begin
            rx_st_ff <= RX_IDLE;
         end else if (rx_st_ff == RX_IDLE) begin
            rx_tk_ff <= 4'h0;
            rx_bit_ff <= 4'h0;
            if (mode == MODE_SHIFT) begin
               // Mode 0 starts only while rx pending is clear
               if (!uart_ctrl_high_ff[HI_RX_PEND] && tick)
                  rx_st_ff <= RX_DATA;
            end else if (!in_sync_ff) begin
               rx_st_ff <= RX_START;
            end
         end else if (tick) begin
            rx_tk_ff <= rx_tk_ff + 4'h1;
            if (rx_tk_ff == TICKS_MID) begin
               unique case (rx_st_ff)
                  RX_START: begin
                     if (in_sync_ff)
                        rx_st_ff <= RX_IDLE; // False start
                  end
                  RX_DATA: begin
                     rx_bit_ff <= rx_bit_ff + 4'h1;
                     rx_sh_ff <= {in_sync_ff, rx_sh_ff[8:1]};
                     if (mode[1] && rx_bit_ff == 4'h8) begin
                        // Ninth bit midpoint ends frame
                        rx_buf_ff <= rx_sh_ff[8:1];
                        rx_ninth <= in_sync_ff;
                        rx_done_evt <= 1'b1;
                        rx_err_evt <= par_en;
                        rx_ok_err <= (^rx_sh_ff[8:1] ^ in_sync_ff) !=
                           uart_ctrl_low_ff[LO_RX_PAR_ODD];
                        rx_st_ff <= RX_STOP;
                     end else if (mode == MODE_SHIFT &&
                        rx_bit_ff == MODE0_BITS_LAST) begin
                        rx_buf_ff <= {in_sync_ff, rx_sh_ff[8:2]};
                        rx_done_evt <= 1'b1;
                        rx_st_ff <= RX_IDLE;
                     end else if (mode == MODE_UART8 &&
                        rx_bit_ff == 4'h7) begin
                        rx_st_ff <= RX_STOP;
                     end
                  end
                  RX_STOP: begin
                     if (mode == MODE_UART8) begin
                        rx_buf_ff <= rx_sh_ff[8:1];
                        rx_done_evt <= 1'b1;
                     end
                     rx_st_ff <= RX_IDLE;
                  end
                  default: rx_st_ff <= RX_IDLE;
               endcase
            end else if (rx_tk_ff == TICKS_LAST &&
               rx_st_ff == RX_START) begin
               rx_st_ff <= RX_DATA;
            end
         end
      end
   end
endmodule : uart_ctrl_parity_baud

/* verilog/uart_pkg.sv */
// Package with register map, field positions and timing constants
package uart_pkg;
   localparam logic [7:0] ADDR_CTRL_HIGH = 8'hF2;
   localparam logic [7:0] ADDR_CTRL_LOW = 8'hF3;
   localparam logic [7:0] ADDR_DATA = 8'hF4;
   localparam logic [7:0] ADDR_BAUD = 8'hF5;
   localparam logic [7:0] CTRL_LOW_RESET = 8'h00;
   localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;
   localparam logic [7:0] BAUD_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Low control field positions
   localparam int LO_TX_PAR_EN = 7;
   localparam int LO_TX_PAR_ODD = 6;
   localparam int LO_RX_PAR_ODD = 5;
   localparam int LO_PAR_ERR = 4;
   localparam int LO_CLK_HI = 3;
   localparam int LO_CLK_LO = 2;
   localparam int LO_TX_IE = 1;
   localparam int LO_TX_PEND = 0;
   // High control field positions
   localparam int HI_MODE_HI = 7;
   localparam int HI_MODE_LO = 6;
   localparam int HI_MCE = 5;
   localparam int HI_RX_EN = 4;
   localparam int HI_TX_NINTH = 3;
   localparam int HI_RX_NINTH = 2;
   localparam int HI_RX_IE = 1;
   localparam int HI_RX_PEND = 0;
   // Sixteen ticks of the serial clock make one bit time
   localparam logic [3:0] TICKS_LAST = 4'hF;
   localparam logic [3:0] TICKS_MID = 4'h7;
   localparam logic [3:0] MODE0_BITS_LAST = 4'h7;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'h0,
      MODE_UART8 = 2'h1,
      MODE_UART9_FIX = 2'h2,
      MODE_UART9_VAR = 2'h3
   } mode_t;
endpackage : uart_pkg

/* verilog/rate_gen.sv */
// Serial clock prescaler and bit-rate tick generator
`timescale 1ns/100ps
module rate_gen
   import uart_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] clk_sel,
   input wire logic [1:0] mode,
   input wire logic [7:0] divisor,
   output logic tick
);
   logic [2:0] pre_ff;
   logic [7:0] div_ff;
   logic pre_tick;
   // Prescale codes 00..11 give divide by 8, 4, 2, 1
   always_comb begin
      unique case (clk_sel)
         2'h0: pre_tick = (pre_ff == 3'h7);
         2'h1: pre_tick = (pre_ff[1:0] == 2'h3);
         2'h2: pre_tick = pre_ff[0];
         2'h3: pre_tick = 1'b1;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_ff <= 3'h0;
      end else begin
         pre_ff <= pre_ff + 3'h1;
      end
   end
   // Divisor plus one, bypassed in the fixed-rate mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 8'h00;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (pre_tick) begin
            if (mode == MODE_UART9_FIX || div_ff >= divisor) begin
               div_ff <= 8'h00;
               tick <= 1'b1;
            end else begin
               div_ff <= div_ff + 8'h01;
            end
         end
      end
   end
endmodule : rate_gen

/* verif/uart_ctrl_monitor.sv */
// Checker for register access and frame timing of the serial port
`timescale 1ns/100ps
module uart_ctrl_monitor
   import uart_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic serial_in_pin,
   input wire logic serial_out_pin_ff,
   input wire logic serial_data_out_ff,
   input wire logic serial_data_oe_ff,
   input wire logic tx_irq_ff,
   input wire logic rx_irq_ff
);
   logic [7:0] lo_sh_ff;
   logic [7:0] hi_sh_ff;
   logic [7:0] baud_sh_ff;
   logic wr_lo;
   logic wr_hi;
   logic tx_ie;
   logic rx_ie;
   logic uart_mode;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Decoded writes and shadow fields
   assign wr_lo = reg_wr && reg_addr == ADDR_CTRL_LOW;
   assign wr_hi = reg_wr && reg_addr == ADDR_CTRL_HIGH;
   assign tx_ie = lo_sh_ff[LO_TX_IE];
   assign rx_ie = hi_sh_ff[HI_RX_IE];
   assign uart_mode = hi_sh_ff[HI_MODE_HI:HI_MODE_LO] != 2'h0;
   // Shadow copies of the written register values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_sh_ff <= 8'h00;
         hi_sh_ff <= 8'h00;
         baud_sh_ff <= 8'h00;
      end else begin
         if (wr_lo) lo_sh_ff <= reg_wdata;
         if (wr_hi) hi_sh_ff <= reg_wdata;
         if (reg_wr && reg_addr == ADDR_BAUD) baud_sh_ff <= reg_wdata;
      end
   end
   unmapped_read_a: assert property (
      reg_rd && !(reg_addr inside {[ADDR_CTRL_HIGH:ADDR_BAUD]})
      |=> reg_rdata_ff == 8'h00)
      else $error("Unmapped read not zero");
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata_ff))
      else $error("Read data moved without a read");
   baud_readback_a: assert property (
      reg_rd && reg_addr == ADDR_BAUD |=> reg_rdata_ff == baud_sh_ff)
      else $error("Divisor readback wrong");
   low_readback_a: assert property (
      reg_rd && reg_addr == ADDR_CTRL_LOW
      |=> (reg_rdata_ff & 8'hEE) == (lo_sh_ff & 8'hEE))
      else $error("Low control readback wrong");
   tx_irq_gate_a: assert property (
      tx_irq_ff |-> $past(tx_ie))
      else $error("Transmit request while disabled");
   rx_irq_gate_a: assert property (
      rx_irq_ff |-> $past(rx_ie))
      else $error("Receive request while disabled");
   tx_start_a: assert property (
      reg_wr && reg_addr == ADDR_DATA && uart_mode
      |-> ##[1:2] !serial_out_pin_ff)
      else $error("No start bit after data write");
   tx_pend_hold_a: assert property (
      tx_irq_ff && !wr_lo && !$past(wr_lo) |=> tx_irq_ff)
      else $error("Transmit pending cleared by itself");
   rx_pend_hold_a: assert property (
      rx_irq_ff && !wr_hi && !$past(wr_hi) |=> rx_irq_ff)
      else $error("Receive pending cleared by itself");
   stop_irq_a: assert property (
      $rose(tx_irq_ff) && uart_mode |-> serial_out_pin_ff)
      else $error("Transmit pending outside stop level");
endmodule : uart_ctrl_monitor

bind uart_ctrl_parity_baud uart_ctrl_monitor mon (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
   .serial_in_pin(serial_in_pin), .serial_out_pin_ff(serial_out_pin_ff),
   .serial_data_out_ff(serial_data_out_ff),
   .serial_data_oe_ff(serial_data_oe_ff), .tx_irq_ff(tx_irq_ff),
   .rx_irq_ff(rx_irq_ff)
);

/* verif/serial_peer.sv */
// Remote serial transmitter model feeding the receive pin
`timescale 1ns/100ps
module serial_peer (
   input wire logic clk,
   output logic data_line
);
   // Line idles at the mark level, as a pulled-up wire would
   initial data_line = 1'b1;
   // Start bit, bits LSB first, then stop level; returns at stop start
   task automatic send(input logic [8:0] d, input int nb, input int bc);
      data_line <= 1'b0;
      repeat (bc) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         data_line <= d[i];
         repeat (bc) @(posedge clk);
      end
      data_line <= 1'b1;
   endtask : send
endmodule : serial_peer

/* verif/tb.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
module tb
   import uart_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata_ff;
   logic serial_in_pin;
   logic serial_out_pin_ff;
   logic serial_data_out_ff;
   logic serial_data_oe_ff;
   logic tx_irq_ff;
   logic rx_irq_ff;
   int errors = 0;
   int cmp_count = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   uart_ctrl_parity_baud uut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .serial_in_pin(serial_in_pin), .serial_out_pin_ff(serial_out_pin_ff),
      .serial_data_out_ff(serial_data_out_ff),
      .serial_data_oe_ff(serial_data_oe_ff), .tx_irq_ff(tx_irq_ff),
      .rx_irq_ff(rx_irq_ff)
   );
   serial_peer peer (.clk(clk), .data_line(serial_in_pin));
   // Bus helpers: inputs change 1 ns after the rising edge
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      tick;
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      reg_rd = 1'b0;
      chk(reg_rdata_ff, exp);
   endtask : rd
   // Counts cycles while the transmit line holds one level
   task automatic hold(input logic v, output int n);
      n = 0;
      while (serial_out_pin_ff === v && n < 2000) begin
         tick;
         n++;
      end
   endtask : hold
   // Sends A5h and checks bit length, bits, ninth bit and pending flag
   task automatic run(input logic [7:0] hi, lo, dv, input int nb, bc,
      input logic nin);
      logic [8:0] bits;
      int n;
      bits = {nin, 8'hA5};
      wr(ADDR_CTRL_HIGH, hi);
      wr(ADDR_CTRL_LOW, lo);
      wr(ADDR_BAUD, dv);
      wr(ADDR_DATA, 8'hA5);
      hold(1'b1, n);
      hold(1'b0, n);
      hold(1'b1, n);
      chk(9'(n), 9'(bc));
      repeat (bc / 2) tick;
      for (int i = 1; i < nb; i++) begin
         chk(serial_out_pin_ff, bits[i]);
         if (i == nb - 1) chk(tx_irq_ff, 1'b0);
         repeat (bc) tick;
      end
      chk(serial_out_pin_ff, 1'b1);
      chk(tx_irq_ff, 1'b1);
      rd(ADDR_CTRL_LOW, lo | 8'h01);
      wr(ADDR_CTRL_LOW, lo);
      tick;
      chk(tx_irq_ff, 1'b0);
      repeat (bc) tick;
   endtask : run
   // Peer sends a frame; checks pending moment, data and parity status
   task automatic rcv(input logic [7:0] hi, lo, input logic [8:0] d,
      input int nb, input logic early, input logic [7:0] lo_exp);
      wr(ADDR_CTRL_HIGH, hi);
      wr(ADDR_CTRL_LOW, lo);
      wr(ADDR_BAUD, 8'h00);
      peer.send(d, nb, 16);
      repeat (6) tick;
      chk(rx_irq_ff, early);
      repeat (14) tick;
      chk(rx_irq_ff, 1'b1);
      rd(ADDR_DATA, d[7:0]);
      rd(ADDR_CTRL_LOW, lo_exp);
      wr(ADDR_CTRL_HIGH, hi);
      tick;
      chk(rx_irq_ff, 1'b0);
   endtask : rcv
   // Prints the verdict and ends the run
   task automatic wrap_up;
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   // Watchdog well beyond the expected run length
   initial begin
      #400000;
      errors++;
      wrap_up;
   end
   // Main sequence
   initial begin
      logic [7:0] pat;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd(ADDR_CTRL_LOW, 8'h00);
      rd(ADDR_BAUD, 8'h00);
      rd(ADDR_DATA, 8'h00);
      rd(8'hF7, 8'h00);
      wr(ADDR_BAUD, 8'hA5);
      rd(ADDR_BAUD, 8'hA5);
      wr(ADDR_CTRL_LOW, 8'hE7);
      rd(ADDR_CTRL_LOW, 8'hE6);
      for (int c = 0; c < 4; c++) begin
         run(8'h40, 8'h02 | 8'(c << 2), 8'h00, 8, 16 * (8 >> c), 1'b0);
      end
      run(8'h40, 8'h0E, 8'h02, 8, 48, 1'b0);
      run(8'h80, 8'hCE, 8'h03, 9, 16, 1'b1);
      run(8'h80, 8'h8E, 8'h03, 9, 16, 1'b0);
      run(8'hC8, 8'h0E, 8'h01, 9, 32, 1'b1);
      run(8'hC0, 8'h4E, 8'h01, 9, 32, 1'b0);
      rcv(8'h52, 8'h0E, 9'h03C, 8, 1'b0, 8'h0E);
      rcv(8'hD2, 8'hAE, 9'h0A5, 9, 1'b1, 8'hBE);
      rcv(8'hD2, 8'hAE, 9'h1A5, 9, 1'b1, 8'hAE);
      // Mode 0 at 32 cycles a bit: clock, data, enable, idle-line receive
      pat = 8'hA5;
      wr(ADDR_BAUD, 8'h01);
      wr(ADDR_CTRL_HIGH, 8'h12);
      wr(ADDR_CTRL_LOW, 8'h0E);
      wr(ADDR_DATA, pat);
      for (int i = 0; i < 8; i++) begin
         repeat (8) tick;
         chk(serial_out_pin_ff, 1'b0);
         repeat (8) tick;
         chk(serial_data_out_ff, pat[i]);
         chk(serial_data_oe_ff, 1'b1);
         if (i == 5) chk(rx_irq_ff, 1'b0);
         if (i == 7) chk(tx_irq_ff, 1'b0);
         repeat (8) tick;
         chk(serial_out_pin_ff, 1'b1);
         repeat (8) tick;
      end
      repeat (16) tick;
      chk(tx_irq_ff, 1'b1);
      chk(serial_data_oe_ff, 1'b0);
      chk(rx_irq_ff, 1'b1);
      rd(ADDR_DATA, 8'hFF);
      rd(ADDR_CTRL_LOW, 8'h0F);
      wrap_up;
   end
endmodule : tb
